// ==== cfbt_pkg.sv ====
package cfbt_pkg;
	// Register offsets
	localparam logic [7:0] OFS_CORE_CONTROL  = 8'h00;
	localparam logic [7:0] OFS_BIT_TIMING_LO = 8'h06;
	localparam logic [7:0] OFS_BIT_TIMING_HI = 8'h07;
	localparam logic [7:0] OFS_TEST_FUNCS    = 8'h0a;
	localparam logic [7:0] OFS_PRESC_EXT     = 8'h0c;
	localparam logic [7:0] OFS_CORE_SETUP    = 8'hbf;
	localparam logic [7:0] OFS_PIN_OUT_SETUP = 8'hc0;
	// Values after reset
	localparam logic [7:0] RST_CORE_CONTROL  = 8'h01;
	localparam logic [7:0] RST_BIT_TIMING_LO = 8'h01;
	localparam logic [6:0] RST_BIT_TIMING_HI = 7'h23;
	localparam logic [3:0] RST_PRESC_EXT     = 4'h0;
	localparam logic [5:0] RST_TEST_FUNCS    = 6'h00;
	localparam logic [5:0] RST_CORE_SETUP    = 6'h00;
	localparam logic       RST_CORE_ENABLE   = 1'b0;
	localparam logic [4:0] RST_PIN_OUT_SETUP = 5'h00;
	// Field positions
	localparam int CTL_INIT_BIT  = 0;
	localparam int CTL_CCE_BIT   = 6;
	localparam int CTL_TEST_BIT  = 7;
	localparam int TST_RX_BIT    = 7;
	localparam int CFG_EN_BIT    = 6;
	localparam int SOF_SEL_LSB   = 4;
	localparam int CLK_IDLE_BIT  = 1;
	localparam int SER_IDLE_BIT  = 0;
	// Time quantum divider: extension weight and the sof width base
	localparam logic [9:0] PRESC_EXT_WEIGHT = 10'h040;
	localparam logic [3:0] SOF_EXP_BASE     = 4'h3;
	localparam logic [4:0] SYNC_SEG_TQ      = 5'h01;
	// Object count and the threshold code that names the last object
	localparam int         NUM_OBJECTS   = 32;
	localparam logic [4:0] THR_LAST_CODE = 5'h00;

	typedef enum logic [1:0] {
		CFBT_SYNC,
		CFBT_SEG1,
		CFBT_SEG2
	} cfbt_seg_t;
endpackage : cfbt_pkg

// ==== cfbt_core.sv ====
`timescale 1ns/100ps
// Operation
// - Data frame arrival clears pending transmit_request
// - Store into lowest available matching object
// - Set new_data_flag; locked while end_of_block zero
// - Last object overwritten when chain full
// - Report flags as before the clear
// - Bit rates from 1 to 1000 kBit/s
// - Quantum is ext*0x40 + prescaler + 1 clocks
// - Bit is sync, seg1, phase seg2
// - Resync by phase error, limited to jump width
// - SOF pulse lasts 2^(select+3) clocks
// - Clock pin idles at programmed level
// - Serial out pin idles at programmed level
// - Setup registers unreadable over SPI, crystal off
// - core_enable low holds core in reset
// - Threshold object reception raises interrupt pin
// - Test register writable only in test mode
// - Test bit 7 shows live receive pin
// - Unused setup bits read as zero
// - Bit timing writable only with CCE and INIT
module cfbt_core (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        ce_i,
	// Register port
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic        reg_via_spi_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic      [7:0]  reg_rdata_o,
	// Message object command port
	input  wire logic        obj_write_i,
	input  wire logic        obj_read_i,
	input  wire logic [4:0]  obj_num_i,
	input  wire logic        obj_transmit_request_i,
	input  wire logic        obj_end_of_block_i,
	input  wire logic        obj_new_data_flag_i,
	input  wire logic        obj_rx_int_enable_i,
	input  wire logic        new_data_clear_select_i,
	input  wire logic        pending_clear_select_i,
	output logic      [3:0]  obj_flags_o,
	// Received frame from the acceptance filter
	input  wire logic        rx_valid_i,
	input  wire logic        rx_remote_i,
	input  wire logic [31:0] rx_match_i,
	output logic             rx_stored_o,
	output logic      [4:0]  rx_obj_o,
	output logic      [31:0] transmit_request_o,
	output logic      [31:0] interrupt_pending_o,
	// Bit timing
	output logic             bit_start_o,
	output logic             sample_point_o,
	output logic             sampled_bit_o,
	output logic      [1:0]  tx_override_o,
	// Pins
	input  wire logic        bus_receive_pin_i,
	input  wire logic        crystal_oscillator_i,
	input  wire logic        clock_source_i,
	input  wire logic        serial_data_i,
	input  wire logic        sof_trigger_i,
	output logic             clock_output_pin_o,
	output logic             serial_out_pin_o,
	output logic             sof_pulse_o,
	output logic             threshold_interrupt_o,
	output logic             core_reset_o
);

	typedef struct packed {
		logic [7:0]         ctl;
		logic [7:0]         btl;
		logic [6:0]         bth;
		logic [3:0]         ext;
		logic [5:0]         tst;
		logic               en;
		logic [4:0]         thr;
		logic [4:0]         pins;
		logic [1:0]         rx_sy;
		logic [1:0]         xt_sy;
		logic               rx_prev;
		logic [7:0]         rdata;
		logic [31:0]        nd;
		logic [31:0]        eob;
		logic [31:0]        transmit_request;
		logic [31:0]        ip;
		logic [31:0]        rxie;
		logic [3:0]         flags;
		logic               stored;
		logic [4:0]         st_obj;
		logic               thr_irq;
		logic [10:0]        sof_cnt;
		logic               sof_act;
		logic [9:0]         pcnt;
		cfbt_pkg::cfbt_seg_t seg;
		logic [4:0]         tqc;
		logic [4:0]         seg1_len;
		logic [4:0]         seg2_len;
		logic               resynced;
		logic               bit_start;
		logic               sample;
		logic               bit_val;
		logic               clk_pin;
		logic               ser_pin;
	} cfbt_state_t;

	cfbt_state_t s_q;
	cfbt_state_t s_d;

	// Lowest set bit; top bit flags that one was found
	function automatic logic [5:0] cfbt_first(input logic [31:0] v);
		cfbt_first = '0;
		for (int i = cfbt_pkg::NUM_OBJECTS - 1; i >= 0; i--) begin
			if (v[i]) begin
				cfbt_first = {1'b1, 5'(i)};
			end
		end
	endfunction : cfbt_first

	function automatic logic [4:0] cfbt_min5(input logic [4:0] a, input logic [4:0] b);
		cfbt_min5 = (a < b) ? a : b;
	endfunction : cfbt_min5

	logic       wr_core;
	logic       bt_open;
	logic [5:0] pick;
	logic [4:0] thr_idx;
	logic [4:0] resync_jump_width;
	logic [9:0] presc_max;
	logic       edge_seen;
	logic [4:0] perr;
	logic       rx_live;
	logic       xt_on;

	always_comb begin
		s_d      = s_q;
		rx_live  = s_q.rx_sy[1];
		xt_on    = s_q.xt_sy[1];
		wr_core  = reg_wr_i && s_q.en;
		bt_open  = s_q.ctl[cfbt_pkg::CTL_CCE_BIT] && s_q.ctl[cfbt_pkg::CTL_INIT_BIT];
		resync_jump_width      = {3'h0, s_q.btl[7:6]} + 5'h01;
		presc_max = 10'({s_q.ext, 6'h00}) + {4'h0, s_q.btl[5:0]};
		pick     = cfbt_first(rx_match_i & ~(s_q.nd & ~s_q.eob));
		thr_idx  = (s_q.thr == cfbt_pkg::THR_LAST_CODE) ? 5'h1f : s_q.thr - 5'h01;
		edge_seen = s_q.rx_prev && !rx_live;
		perr     = '0;

		s_d.rx_sy   = {s_q.rx_sy[0], bus_receive_pin_i};
		s_d.xt_sy   = {s_q.xt_sy[0], crystal_oscillator_i};
		s_d.stored  = 1'b0;
		s_d.thr_irq = 1'b0;
		s_d.bit_start = 1'b0;
		s_d.sample  = 1'b0;

		// Register writes
		if (reg_wr_i) begin
			case (reg_addr_i)
				cfbt_pkg::OFS_CORE_SETUP: begin
					s_d.en  = reg_wdata_i[cfbt_pkg::CFG_EN_BIT];
					s_d.thr = reg_wdata_i[4:0];
				end
				cfbt_pkg::OFS_PIN_OUT_SETUP: s_d.pins = {reg_wdata_i[6:4], reg_wdata_i[1:0]};
				cfbt_pkg::OFS_CORE_CONTROL:  if (wr_core) s_d.ctl = reg_wdata_i;
				cfbt_pkg::OFS_TEST_FUNCS: begin
					if (wr_core && s_q.ctl[cfbt_pkg::CTL_TEST_BIT]) begin
						s_d.tst = reg_wdata_i[5:0];
					end
				end
				cfbt_pkg::OFS_BIT_TIMING_LO: if (wr_core && bt_open) s_d.btl = reg_wdata_i;
				cfbt_pkg::OFS_BIT_TIMING_HI: if (wr_core && bt_open) s_d.bth = reg_wdata_i[6:0];
				cfbt_pkg::OFS_PRESC_EXT:     if (wr_core && bt_open) s_d.ext = reg_wdata_i[3:0];
				default: ;
			endcase
		end

		// Register reads; unmapped offsets answer zero
		if (reg_rd_i) begin
			case (reg_addr_i)
				cfbt_pkg::OFS_CORE_CONTROL:  s_d.rdata = s_q.ctl;
				cfbt_pkg::OFS_BIT_TIMING_LO: s_d.rdata = s_q.btl;
				cfbt_pkg::OFS_BIT_TIMING_HI: s_d.rdata = {1'b0, s_q.bth};
				cfbt_pkg::OFS_PRESC_EXT:     s_d.rdata = {4'h0, s_q.ext};
				cfbt_pkg::OFS_TEST_FUNCS:    s_d.rdata = {rx_live, 1'b0, s_q.tst};
				// Setup registers live off the crystal; SPI reads them as zero then
				cfbt_pkg::OFS_CORE_SETUP:
					s_d.rdata = (reg_via_spi_i && !xt_on) ? 8'h00 :
						{1'b0, s_q.en, 1'b0, s_q.thr};
				cfbt_pkg::OFS_PIN_OUT_SETUP:
					s_d.rdata = (reg_via_spi_i && !xt_on) ? 8'h00 :
						{1'b0, s_q.pins[4:2], 2'b00, s_q.pins[1:0]};
				default: s_d.rdata = 8'h00;
			endcase
		end

		// Host object access; applied before reception so a store wins
		if (obj_write_i) begin
			s_d.transmit_request[obj_num_i] = obj_transmit_request_i;
			s_d.eob[obj_num_i]  = obj_end_of_block_i;
			s_d.nd[obj_num_i]   = obj_new_data_flag_i;
			s_d.rxie[obj_num_i] = obj_rx_int_enable_i;
		end else if (obj_read_i) begin
			s_d.flags = {s_q.ip[obj_num_i], s_q.nd[obj_num_i],
				s_q.transmit_request[obj_num_i], s_q.eob[obj_num_i]};
			if (new_data_clear_select_i) s_d.nd[obj_num_i] = 1'b0;
			if (pending_clear_select_i)  s_d.ip[obj_num_i] = 1'b0;
		end

		// Data frame store: lowest free object, last object when chain full
		if (rx_valid_i && !rx_remote_i && pick[5]) begin
			s_d.nd[pick[4:0]]   = 1'b1;
			s_d.transmit_request[pick[4:0]] = 1'b0;
			if (s_q.rxie[pick[4:0]]) s_d.ip[pick[4:0]] = 1'b1;
			s_d.stored  = 1'b1;
			s_d.st_obj  = pick[4:0];
			s_d.thr_irq = (pick[4:0] == thr_idx);
		end

		// Bit timing, idle while initialising
		if (s_q.ctl[cfbt_pkg::CTL_INIT_BIT]) begin
			s_d.pcnt = '0;
			s_d.seg  = cfbt_pkg::CFBT_SYNC;
			s_d.tqc  = '0;
		end else if (s_q.pcnt != presc_max) begin
			s_d.pcnt = s_q.pcnt + 10'h001;
		end else begin
			s_d.pcnt    = '0;
			s_d.rx_prev = rx_live;
			case (s_q.seg)
				cfbt_pkg::CFBT_SYNC: begin
					s_d.bit_start = 1'b1;
					s_d.resynced  = 1'b0;
					s_d.seg1_len  = {1'b0, s_q.bth[3:0]} + 5'h01;
					s_d.seg2_len  = {2'b00, s_q.bth[6:4]} + 5'h01;
					s_d.seg       = cfbt_pkg::CFBT_SEG1;
					s_d.tqc       = cfbt_pkg::SYNC_SEG_TQ;
				end
				cfbt_pkg::CFBT_SEG1: begin
					// Late edge: stretch seg1 by phase error, capped at jump width
					if (edge_seen && !s_q.resynced) begin
						perr = s_q.tqc;
						s_d.seg1_len = s_q.seg1_len + cfbt_min5(perr, resync_jump_width);
						s_d.resynced = 1'b1;
					end
					if (s_q.tqc >= s_d.seg1_len) begin
						s_d.seg     = cfbt_pkg::CFBT_SEG2;
						s_d.tqc     = 5'h01;
						s_d.sample  = 1'b1;
						s_d.bit_val = rx_live;
					end else begin
						s_d.tqc = s_q.tqc + 5'h01;
					end
				end
				cfbt_pkg::CFBT_SEG2: begin
					// Early edge: cut seg2 short, never by more than jump width
					if (edge_seen && !s_q.resynced) begin
						perr = s_q.seg2_len - s_q.tqc + 5'h01;
						s_d.seg2_len = s_q.seg2_len - cfbt_min5(perr, resync_jump_width);
						s_d.resynced = 1'b1;
					end
					if (s_q.tqc >= s_d.seg2_len) begin
						s_d.seg = cfbt_pkg::CFBT_SYNC;
						s_d.tqc = '0;
					end else begin
						s_d.tqc = s_q.tqc + 5'h01;
					end
				end
				default: s_d.seg = cfbt_pkg::CFBT_SYNC;
			endcase
		end

		// Core held in reset while disabled
		if (!s_q.en) begin
			s_d.ctl  = cfbt_pkg::RST_CORE_CONTROL;
			s_d.btl  = cfbt_pkg::RST_BIT_TIMING_LO;
			s_d.bth  = cfbt_pkg::RST_BIT_TIMING_HI;
			s_d.ext  = cfbt_pkg::RST_PRESC_EXT;
			s_d.tst  = cfbt_pkg::RST_TEST_FUNCS;
			s_d.nd   = '0;
			s_d.eob  = '0;
			s_d.transmit_request = '0;
			s_d.ip   = '0;
			s_d.rxie = '0;
			s_d.stored  = 1'b0;
			s_d.thr_irq = 1'b0;
		end

		// Start-of-frame pulse: 2^(select+3) clk_i periods
		if (sof_trigger_i) begin
			s_d.sof_act = 1'b1;
			// Exponent widened to four bits so selects 5 to 7 do not wrap
			s_d.sof_cnt = 11'((11'h001 << ({1'b0, s_q.pins[4:2]} + cfbt_pkg::SOF_EXP_BASE))
				- 11'h001);
		end else if (s_q.sof_cnt != '0) begin
			s_d.sof_cnt = s_q.sof_cnt - 11'h001;
		end else begin
			s_d.sof_act = 1'b0;
		end

		s_d.clk_pin = xt_on ? clock_source_i : s_q.pins[cfbt_pkg::CLK_IDLE_BIT];
		s_d.ser_pin = xt_on ? serial_data_i : s_q.pins[cfbt_pkg::SER_IDLE_BIT];
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_q      <= '0;
			s_q.ctl  <= cfbt_pkg::RST_CORE_CONTROL;
			s_q.btl  <= cfbt_pkg::RST_BIT_TIMING_LO;
			s_q.bth  <= cfbt_pkg::RST_BIT_TIMING_HI;
			s_q.ext  <= cfbt_pkg::RST_PRESC_EXT;
			s_q.en   <= cfbt_pkg::RST_CORE_ENABLE;
			s_q.thr  <= cfbt_pkg::RST_CORE_SETUP[4:0];
			s_q.pins <= cfbt_pkg::RST_PIN_OUT_SETUP;
			s_q.seg  <= cfbt_pkg::CFBT_SYNC;
			s_q.rx_prev <= 1'b1;
			s_q.bit_val <= 1'b1;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_o           = s_q.rdata;
	assign obj_flags_o           = s_q.flags;
	assign rx_stored_o           = s_q.stored;
	assign rx_obj_o              = s_q.st_obj;
	assign transmit_request_o    = s_q.transmit_request;
	assign interrupt_pending_o   = s_q.ip;
	assign bit_start_o           = s_q.bit_start;
	assign sample_point_o        = s_q.sample;
	assign sampled_bit_o         = s_q.bit_val;
	assign tx_override_o         = s_q.tst[1:0];
	assign clock_output_pin_o    = s_q.clk_pin;
	assign serial_out_pin_o      = s_q.ser_pin;
	assign sof_pulse_o           = s_q.sof_act;
	assign threshold_interrupt_o = s_q.thr_irq;
	assign core_reset_o          = !s_q.en;

endmodule : cfbt_core

// ==== cfbt_bus_node.sv ====
`timescale 1ns/100ps
module cfbt_bus_node (
	input  wire logic       clk_i,
	input  wire logic       dom_req_i,
	input  wire logic [9:0] dom_len_i,
	output logic            bus_level_o
);
	logic [9:0] left_q = 10'h000;
	// Bus floats back to recessive through the transceiver once no node drives it
	always_ff @(posedge clk_i) begin
		if (dom_req_i)
			left_q <= dom_len_i;
		else if (left_q != 10'h000)
			left_q <= left_q - 10'h001;
	end
	assign bus_level_o = (left_q == 10'h000);
endmodule : cfbt_bus_node

// ==== cfbt_core_assertions.sv ====
`timescale 1ns/100ps
module cfbt_core_assertions (
	input wire logic        clk_i,
	input wire logic        srst_i,
	input wire logic        ce_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic        reg_via_spi_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        rx_valid_i,
	input wire logic        rx_remote_i,
	input wire logic [31:0] rx_match_i,
	input wire logic        rx_stored_o,
	input wire logic [4:0]  rx_obj_o,
	input wire logic [31:0] transmit_request_o,
	input wire logic        crystal_oscillator_i,
	input wire logic        clock_output_pin_o,
	input wire logic        serial_out_pin_o,
	input wire logic        sof_trigger_i,
	input wire logic        sof_pulse_o,
	input wire logic        threshold_interrupt_o,
	input wire logic        core_reset_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	logic [10:0] sof_len_q;
	logic [31:0] match_q;
	always_ff @(posedge clk_i) begin
		match_q <= rx_match_i;
		if (srst_i || sof_trigger_i || !sof_pulse_o)
			sof_len_q <= 11'h000;
		else
			sof_len_q <= sof_len_q + 11'h001;
	end
	property p_core_hold;
		reg_wr_i && ce_i && reg_addr_i == 8'hbf |=> core_reset_o == !$past(reg_wdata_i[6]);
	endproperty
	a_core_hold: assert property (p_core_hold) else $error("core reset wrong");
	property p_pin_idle;
		(!crystal_oscillator_i && !reg_wr_i)[*4] |=> $stable({clock_output_pin_o, serial_out_pin_o});
	endproperty
	a_pin_idle: assert property (p_pin_idle) else $error("idle pins moved");
	property p_spi_blind;
		reg_rd_i && ce_i && reg_via_spi_i && (reg_addr_i == 8'hbf || reg_addr_i == 8'hc0)
		&& !crystal_oscillator_i && !$past(crystal_oscillator_i)
		&& !$past(crystal_oscillator_i, 2) |=> reg_rdata_o == 8'h00;
	endproperty
	a_spi_blind: assert property (p_spi_blind) else $error("setup read over spi");
	property p_rsvd;
		reg_rd_i && ce_i && reg_addr_i == 8'hc0 |=> reg_rdata_o[7] == 1'b0 && reg_rdata_o[3:2] == 2'b00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
	property p_stored;
		rx_stored_o |-> $past(rx_valid_i && !rx_remote_i) && match_q[rx_obj_o];
	endproperty
	a_stored: assert property (p_stored) else $error("store without match");
	property p_transmit_request_clr;
		rx_stored_o |-> !transmit_request_o[rx_obj_o];
	endproperty
	a_transmit_request_clr: assert property (p_transmit_request_clr) else $error("request kept");
	property p_thr;
		threshold_interrupt_o |-> rx_stored_o;
	endproperty
	a_thr: assert property (p_thr) else $error("stray threshold pulse");
	property p_sof_start;
		sof_trigger_i && ce_i |=> sof_pulse_o;
	endproperty
	a_sof_start: assert property (p_sof_start) else $error("sof not started");
	property p_sof_len;
		sof_len_q <= 11'h400;
	endproperty
	a_sof_len: assert property (p_sof_len) else $error("sof too long");
endmodule : cfbt_core_assertions
bind cfbt_core cfbt_core_assertions chk (.*);

// ==== testbench.sv ====
`timescale 1ns/100ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module testbench;
	logic        clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic        reg_via_spi_i = 1'b0, obj_write_i = 1'b0, obj_read_i = 1'b0;
	logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
	logic [4:0]  obj_num_i = 5'h00, rx_obj_o;
	logic        obj_transmit_request_i = 1'b0, obj_end_of_block_i = 1'b0;
	logic        obj_new_data_flag_i = 1'b0, obj_rx_int_enable_i = 1'b1;
	logic        new_data_clear_select_i = 1'b1, pending_clear_select_i = 1'b1;
	logic [3:0]  obj_flags_o;
	logic        rx_valid_i = 1'b0, rx_remote_i = 1'b0, rx_stored_o;
	logic [31:0] rx_match_i = 32'h0, transmit_request_o, interrupt_pending_o, rng = 32'h4d;
	logic        bit_start_o, sample_point_o, sampled_bit_o, bus_receive_pin_i;
	logic [1:0]  tx_override_o, rd_d, src_d;
	logic        crystal_oscillator_i = 1'b0, clock_source_i = 1'b0, serial_data_i = 1'b0;
	logic        sof_trigger_i = 1'b0, clock_output_pin_o, serial_out_pin_o, sof_pulse_o;
	logic        threshold_interrupt_o, core_reset_o, dom_req = 1'b0, pin_chk = 1'b0;
	logic [8:0]  rq[$], ex;
	logic [5:0]  sq[$], es;
	int          fails = 0, tests_run = 0, n;
	cfbt_core dut (.*);
	cfbt_bus_node node (.clk_i, .dom_req_i(dom_req), .dom_len_i(10'h3ff),
		.bus_level_o(bus_receive_pin_i));
	always #25 clk_i = ~clk_i;
	function automatic logic [31:0] xorshift(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		xorshift = x ^ (x << 5);
	endfunction : xorshift
	always @(negedge clk_i) begin
		rng = xorshift(rng);
		{clock_source_i, serial_data_i} = rng[1:0];
	end
	always @(posedge clk_i) begin
		rd_d = {obj_read_i, reg_rd_i};
		src_d = {clock_source_i, serial_data_i};
		#1;
		if (rd_d != 2'b00) begin
			ex = rq.pop_front();
			if (ex[8])
				`CHK("obj_flags", ex[3:0], obj_flags_o)
			else
				`CHK("reg_rdata", ex[7:0], reg_rdata_o)
		end
		if (rx_stored_o) begin
			es = sq.pop_front();
			`CHK("rx_obj", es[4:0], rx_obj_o)
			`CHK("thr_irq", es[5], threshold_interrupt_o)
		end
		if (pin_chk)
			`CHK("pins", src_d, {clock_output_pin_o, serial_out_pin_o})
	end
	task automatic pulse(ref logic s);
		@(negedge clk_i);
		s = 1'b1;
		@(negedge clk_i);
		s = 1'b0;
	endtask : pulse
	task automatic wr(logic [7:0] a, logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		pulse(reg_wr_i);
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] e, logic spi = 1'b0);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_via_spi_i = spi;
		rq.push_back({1'b0, e});
		pulse(reg_rd_i);
	endtask : rd
	task automatic ow(logic [4:0] o, logic t, logic e);
		@(negedge clk_i);
		{obj_num_i, obj_transmit_request_i, obj_end_of_block_i} = {o, t, e};
		pulse(obj_write_i);
	endtask : ow
	task automatic ord(logic [4:0] o, logic [3:0] e);
		@(negedge clk_i);
		obj_num_i = o;
		rq.push_back({5'h10, e});
		pulse(obj_read_i);
	endtask : ord
	task automatic rx(logic [5:0] e);
		@(negedge clk_i);
		rx_match_i = 32'h7;
		sq.push_back(e);
		pulse(rx_valid_i);
	endtask : rx
	task automatic till(ref logic s, output int c);
		c = 0;
		do begin
			@(negedge clk_i);
			c++;
		end while (!s && c < 5000);
	endtask : till
	task automatic close_out();
		`CHK("queues", 0, rq.size() + sq.size())
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	initial begin
		#(50 * 40000);
		fails++;
		close_out();
	end
	initial begin
		repeat (20) @(negedge clk_i);
		srst_i = 1'b0;
		wr(8'h00, 8'h41);
		rd(8'h00, 8'h01);
		wr(8'hbf, 8'h43);
		rd(8'hbf, 8'h43);
		`CHK("core_reset", 1'b0, core_reset_o)
		wr(8'hc0, 8'hff);
		rd(8'hc0, 8'h73);
		rd(8'hc0, 8'h00, 1'b1);
		`CHK("clk_pin", 2'b11, {clock_output_pin_o, serial_out_pin_o})
		wr(8'hc0, 8'h01);
		repeat (3) @(negedge clk_i);
		`CHK("clk_pin", 2'b01, {clock_output_pin_o, serial_out_pin_o})
		crystal_oscillator_i = 1'b1;
		repeat (4) @(negedge clk_i);
		pin_chk = 1'b1;
		rd(8'hc0, 8'h01, 1'b1);
		pin_chk = 1'b0;
		for (int s = 0; s < 8; s++) begin
			wr(8'hc0, 8'(s << 4));
			pulse(sof_trigger_i);
			n = 0;
			while (sof_pulse_o && n < 2000) begin
				n++;
				@(negedge clk_i);
			end
			`CHK("sof_len", 1 << (s + 3), n)
		end
		wr(8'h0a, 8'h15);
		rd(8'h0a, 8'h80);
		wr(8'h00, 8'h81);
		wr(8'h0a, 8'h3f);
		rd(8'h0a, 8'hbf);
		`CHK("tx_override", 2'b11, tx_override_o)
		pulse(dom_req);
		repeat (4) @(negedge clk_i);
		rd(8'h0a, 8'h3f);
		wr(8'h0a, 8'h00);
		wr(8'h00, 8'h01);
		wr(8'h06, 8'h55);
		rd(8'h06, 8'h01);
		wr(8'h00, 8'h41);
		wr(8'h06, 8'h03);
		wr(8'h07, 8'h12);
		wr(8'h0c, 8'h01);
		rd(8'h07, 8'h12);
		wr(8'h00, 8'h00);
		till(bit_start_o, n);
		// Bit start marks the end of the sync quantum: seg1 is 3 tq, then seg2 plus sync
		till(sample_point_o, n);
		`CHK("seg1_span", 3 * 68, n)
		`CHK("sampled_bit", 1'b0, sampled_bit_o)
		till(bit_start_o, n);
		`CHK("seg2_span", (2 + 1) * 68, n)
		ow(5'd0, 1'b1, 1'b0);
		ow(5'd1, 1'b0, 1'b0);
		ow(5'd2, 1'b0, 1'b1);
		`CHK("transmit_request", 1'b1, transmit_request_o[0])
		rx({1'b0, 5'd0});
		rx({1'b0, 5'd1});
		rx({1'b1, 5'd2});
		rx({1'b1, 5'd2});
		ord(5'd0, 4'hc);
		rx({1'b0, 5'd0});
		ord(5'd1, 4'hc);
		ord(5'd1, 4'h0);
		// Remote frame must not be stored into the free object 1
		rx_remote_i = 1'b1;
		pulse(rx_valid_i);
		rx_remote_i = 1'b0;
		ce_i = 1'b0;
		wr(8'hbf, 8'h00);
		ce_i = 1'b1;
		rd(8'hbf, 8'h43);
		repeat (4) @(negedge clk_i);
		`CHK("int_pending", 32'h5, interrupt_pending_o)
		`CHK("transmit_request_all", 32'h0, transmit_request_o)
		close_out();
	end
endmodule : testbench
